// ---- dv/dmrm_master_model.sv ----
// bus master model: issues one register request and collects the answer
`timescale 1ns/1ps
`default_nettype none
module dmrm_master_model (
    input wire logic i_mclk,
    input wire logic i_rsp_valid,
    input wire logic [7:0] i_rsp_code,
    input wire logic [15:0] i_rsp_rdata,
    input wire logic i_commit,
    input wire logic i_nv_store,
    output logic o_req_valid,
    output logic o_req_write,
    output logic o_req_bcast,
    output logic [15:0] o_req_addr,
    output logic [15:0] o_req_wdata
);
    initial begin
        o_req_valid = 1'b0;
        o_req_write = 1'b0;
        o_req_bcast = 1'b0;
        o_req_addr = 16'h5555;
        o_req_wdata = 16'hAAAA;
    end
    // nonvolatile commits are only sent when the caller asks, never repeated
    task automatic xfer(input logic w, input logic b, input logic [15:0] a,
            input logic [15:0] d, output logic [7:0] code, output logic [15:0] rd,
            output logic [2:0] fl);
        @(posedge i_mclk);
        o_req_valid <= 1'b1;
        o_req_write <= w;
        o_req_bcast <= b;
        o_req_addr <= a;
        o_req_wdata <= d;
        @(posedge i_mclk);
        o_req_valid <= 1'b0;
        // stale fields flip so a late sample cannot match by luck
        o_req_addr <= ~a;
        o_req_wdata <= ~d;
        #1;
        code = i_rsp_code;
        rd = i_rsp_rdata;
        fl = {i_rsp_valid, i_commit, i_nv_store};
    endtask
endmodule // dmrm_master_model
`default_nettype wire

// ---- dv/tb_drive_monitor_register_map.sv ----
// self-checking bench for the drive monitor register map
`timescale 1ns/1ps
`default_nettype none
module tb_drive_monitor_register_map;
    import dmrm_pkg::*;
    logic i_mclk, i_reset, i_req_valid, i_req_write, i_req_bcast, i_running;
    logic i_run_src_not_comm, i_overtorque, i_ref_lost, i_retrying, i_fault;
    logic i_comm_timeout, i_fault_reset, o_rsp_valid, o_rsp_err, o_run_cmd;
    logic o_reverse, o_ext_fault, o_fault_reset_req, o_commit, o_nv_store;
    logic [15:0] i_req_addr, i_req_wdata, o_rsp_rdata, i_local_op, o_op_word, o_freq_ref;
    logic [9:0] i_status_low;
    logic [2:0] i_relay_out, fl;
    logic [1:0] i_photocoupler_output;
    logic [6:0] i_link_err_evt;
    logic [3:0] o_contact_input;
    logic [7:0] gc;
    logic [15:0] gd;
    logic [15:0] mon [10];
    logic [15:0] mon_a [10] = '{16'h0031, 16'h0032, 16'h0033, 16'h0038, 16'h0039,
        16'h003A, 16'h003B, 16'h003C, 16'h003E, 16'h003F};
    dmrm_code_e o_rsp_code;
    int err_count, tests_run;

    dmrm_top dut_u (.i_mclk, .i_reset, .i_req_valid, .i_req_write, .i_req_bcast,
        .i_req_addr, .i_req_wdata, .o_rsp_valid, .o_rsp_err, .o_rsp_code, .o_rsp_rdata,
        .i_running, .i_status_low, .i_run_src_not_comm, .i_overtorque, .i_ref_lost,
        .i_retrying, .i_fault, .i_comm_timeout, .i_relay_out, .i_photocoupler_output,
        .i_dc_bus(mon[0]), .i_torque(mon[1]), .i_output_power_monitor_item(mon[2]),
        .i_pid_feedback(mon[3]), .i_pid_input(mon[4]), .i_pid_output(mon[5]),
        .i_fw_main(mon[6]), .i_fw_flash(mon[7]), .i_kva(mon[8]), .i_ctrl_method(mon[9]),
        .i_link_err_evt, .i_fault_reset, .i_local_op, .o_op_word, .o_run_cmd, .o_reverse,
        .o_ext_fault, .o_fault_reset_req, .o_contact_input, .o_freq_ref, .o_commit,
        .o_nv_store);

    dmrm_master_model m_u (.i_mclk(i_mclk), .i_rsp_valid(o_rsp_valid),
        .i_rsp_code(o_rsp_code), .i_rsp_rdata(o_rsp_rdata), .i_commit(o_commit),
        .i_nv_store(o_nv_store), .o_req_valid(i_req_valid), .o_req_write(i_req_write),
        .o_req_bcast(i_req_bcast), .o_req_addr(i_req_addr), .o_req_wdata(i_req_wdata));

    task automatic close_out();
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one request; answer pulse, code and read data all judged
    task automatic op(input logic w, input logic b, input logic [15:0] a,
            input logic [15:0] d, input logic [7:0] ec, input logic [15:0] ed);
        m_u.xfer(w, b, a, d, gc, gd, fl);
        chk({15'h0000, fl[2]}, 16'h0001);
        chk({15'h0000, o_rsp_err}, {15'h0000, ec != 8'h00});
        chk({8'h00, gc}, {8'h00, ec});
        chk(gd, ed);
    endtask

    task automatic t_status();
        @(posedge i_mclk);
        i_status_low <= 10'h2A5;
        {i_comm_timeout, i_fault, i_retrying, i_ref_lost, i_overtorque,
            i_run_src_not_comm} <= 6'b100101;
        op(0, 0, 16'h002C, 16'h0000, 8'h00, 16'hD6A5);
        i_status_low <= 10'h15A;
        {i_comm_timeout, i_fault, i_retrying, i_ref_lost, i_overtorque,
            i_run_src_not_comm} <= 6'b011010;
        op(0, 0, 16'h002C, 16'h0000, 8'h00, 16'h695A);
    endtask

    task automatic t_outputs();
        @(posedge i_mclk);
        i_relay_out <= 3'b101;
        i_photocoupler_output <= 2'b10;
        op(0, 0, 16'h002D, 16'h0000, 8'h00, 16'h0015);
        i_relay_out <= 3'b010;
        i_photocoupler_output <= 2'b01;
        op(0, 0, 16'h002D, 16'h0000, 8'h00, 16'h000A);
        for (int i = 0; i < 10; i++) begin
            op(0, 0, mon_a[i], 16'h0000, 8'h00, mon[i]);
        end
    endtask

    task automatic t_link();
        @(posedge i_mclk);
        i_link_err_evt <= 7'h7F;
        @(posedge i_mclk);
        i_link_err_evt <= 7'h00;
        op(0, 0, 16'h003D, 16'h0000, 8'h00, 16'h007B);
        op(0, 0, 16'h003D, 16'h0000, 8'h00, 16'h007B);
        // new events in the clearing cycle survive the clear
        i_running <= 1'b1;
        i_fault_reset <= 1'b1;
        i_link_err_evt <= 7'h41;
        @(posedge i_mclk);
        i_fault_reset <= 1'b0;
        i_link_err_evt <= 7'h00;
        i_running <= 1'b0;
        op(0, 0, 16'h003D, 16'h0000, 8'h00, 16'h0041);
    endtask

    // undefined bits of the broadcast word must keep following the local word
    task automatic t_bcast();
        i_local_op <= 16'h0F0C;
        op(1, 1, 16'h0001, 16'hFFFF, 8'h00, 16'h0000);
        @(posedge i_mclk);
        #1;
        chk(o_op_word, 16'hFF3F);
        chk({8'h00, o_contact_input, o_fault_reset_req, o_ext_fault, o_reverse,
            o_run_cmd}, 16'h00FF);
        op(0, 0, 16'h003D, 16'h0000, 8'h00, 16'h0000);
        op(0, 0, 16'h0001, 16'h0000, 8'h00, 16'hF033);
        i_local_op <= 16'h00C0;
        op(1, 1, 16'h0001, 16'h1001, 8'h00, 16'h0000);
        @(posedge i_mclk);
        #1;
        chk(o_op_word, 16'h10C1);
        chk({8'h00, o_contact_input, o_fault_reset_req, o_ext_fault, o_reverse,
            o_run_cmd}, 16'h0011);
        op(0, 0, 16'h0001, 16'h0000, 8'h00, 16'h1001);
        op(1, 1, 16'h0002, 16'h7530, 8'h00, 16'h0000);
        @(posedge i_mclk);
        #1;
        chk(o_freq_ref, 16'h7530);
        op(1, 1, 16'h0000, 16'h0000, 8'h00, 16'h0000);
        op(1, 1, 16'h0003, 16'h0001, 8'h02, 16'h0000);
        op(0, 1, 16'h0001, 16'h0000, 8'h02, 16'h0000);
    endtask

    task automatic t_commit();
        op(1, 0, 16'h0100, 16'h1234, 8'h00, 16'h0000);
        op(0, 0, 16'h0100, 16'h0000, 8'h00, 16'h0000);
        op(1, 0, 16'h0910, 16'h0000, 8'h00, 16'h0000);
        chk({13'h0000, fl}, 16'h0006);
        op(0, 0, 16'h0100, 16'h0000, 8'h00, 16'h1234);
        op(1, 0, 16'h0101, 16'h5678, 8'h00, 16'h0000);
        op(1, 0, 16'h0900, 16'h0001, 8'h00, 16'h0000);
        chk({13'h0000, fl}, 16'h0004);
        op(0, 0, 16'h0101, 16'h0000, 8'h00, 16'h0000);
        op(1, 0, 16'h0900, 16'h0000, 8'h00, 16'h0000);
        chk({13'h0000, fl}, 16'h0007);
        op(0, 0, 16'h0101, 16'h0000, 8'h00, 16'h5678);
        op(0, 0, 16'h0900, 16'h0000, 8'h02, 16'h0000);
        op(0, 0, 16'h0910, 16'h0000, 8'h02, 16'h0000);
        op(0, 0, 16'h002E, 16'h0000, 8'h02, 16'h0000);
    endtask

    task automatic t_running();
        i_running <= 1'b1;
        op(1, 0, 16'h0102, 16'hABCD, 8'h22, 16'h0000);
        op(1, 0, 16'h0910, 16'h0000, 8'h22, 16'h0000);
        chk({13'h0000, fl}, 16'h0004);
        op(1, 0, 16'h0031, 16'h1111, 8'h22, 16'h0000);
        i_running <= 1'b0;
        op(1, 0, 16'h0910, 16'h0000, 8'h00, 16'h0000);
        op(0, 0, 16'h0102, 16'h0000, 8'h00, 16'h0000);
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    initial begin
        repeat (4000) @(posedge i_mclk);
        err_count++;
        close_out();
    end

    initial begin
        i_reset = 1'b1;
        i_running = 1'b0;
        i_status_low = 10'h000;
        {i_comm_timeout, i_fault, i_retrying, i_ref_lost, i_overtorque,
            i_run_src_not_comm} = 6'b000000;
        i_relay_out = 3'b000;
        i_photocoupler_output = 2'b00;
        i_link_err_evt = 7'h00;
        i_fault_reset = 1'b0;
        i_local_op = 16'h0000;
        for (int i = 0; i < 10; i++) begin
            mon[i] = 16'hA5A0 + 16'(i);
        end
        mon[3] = 16'h03E8;
        mon[4] = 16'hFC18;
        mon[5] = 16'h8001;
        repeat (12) @(posedge i_mclk);
        i_reset <= 1'b0;
        t_status();
        t_outputs();
        t_link();
        t_bcast();
        t_commit();
        t_running();
        close_out();
    end
endmodule // tb_drive_monitor_register_map
`default_nettype wire

// ---- hdl/dmrm_defs.svh ----
// register numbers, field positions and codes of the drive monitor map
`ifndef DMRM_DEFS_SVH
`define DMRM_DEFS_SVH
`define DMRM_A_BC_NONE 16'h0000
`define DMRM_A_BC_OP 16'h0001
`define DMRM_A_BC_FREQ 16'h0002
`define DMRM_A_DRV_STAT 16'h002C
`define DMRM_A_OUT_STAT 16'h002D
`define DMRM_A_DC_BUS 16'h0031
`define DMRM_A_TORQUE 16'h0032
`define DMRM_A_POWER 16'h0033
`define DMRM_A_PID_FB 16'h0038
`define DMRM_A_PID_IN 16'h0039
`define DMRM_A_PID_OUT 16'h003A
`define DMRM_A_FW_MAIN 16'h003B
`define DMRM_A_FW_FLASH 16'h003C
`define DMRM_A_LINK_ERR 16'h003D
`define DMRM_A_KVA 16'h003E
`define DMRM_A_CTRL 16'h003F
`define DMRM_A_COMMIT_NV 16'h0900
`define DMRM_A_COMMIT_RAM 16'h0910
`define DMRM_A_PARAM_BASE 16'h0100
`define DMRM_PARAM_DEPTH 8
`define DMRM_PARAM_IW 3
`define DMRM_BC_DEF_MASK 16'hF033
`define DMRM_LINK_ERR_MASK 7'h7B
`define DMRM_OUT_STAT_MASK 16'h001F
`define DMRM_FREQ_FULL 16'h7530
`define DMRM_CODE_OK 8'h00
`define DMRM_CODE_BAD_REG 8'h02
`define DMRM_CODE_WMODE 8'h22
`define DMRM_BIT_RUN 0
`define DMRM_BIT_REV 1
`define DMRM_BIT_EXT_FAULT 4
`define DMRM_BIT_FAULT_RST 5
`define DMRM_BIT_CONTACT_LO 12
`endif

// ---- hdl/dmrm_param_bank.sv ----
// staged and working parameter words
`timescale 1ns/1ps
`default_nettype none
module dmrm_param_bank (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_we,
    input wire logic [2:0] i_widx,
    input wire logic [15:0] i_wdata,
    input wire logic i_commit,
    input wire logic [2:0] i_ridx,
    output logic [15:0] o_rdata
);
    typedef struct packed {
        logic [7:0][15:0] stage;
        logic [7:0][15:0] work;
    } dmrm_bank_s;
    dmrm_bank_s q;
    dmrm_bank_s next_q;

    always_comb begin
        next_q = q;
        if (i_we) begin
            next_q.stage[i_widx] = i_wdata; // R13
        end
        if (i_commit) begin
            next_q.work = q.stage; // R13
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign o_rdata = q.work[i_ridx];

    property p_work_stable;
        @(posedge i_mclk) disable iff (i_reset)
        !i_commit |=> $stable(q.work);
    endproperty
    a_work_stable: assert property (p_work_stable) else $error("work changed w/o commit"); // R13
endmodule // dmrm_param_bank
`default_nettype wire

// ---- hdl/dmrm_pkg.sv ----
// types shared by the drive monitor register map
`include "dmrm_defs.svh"
package dmrm_pkg;
    typedef enum logic [7:0] {
        DMRM_OK = `DMRM_CODE_OK,
        DMRM_BAD_REG = `DMRM_CODE_BAD_REG,
        DMRM_WMODE = `DMRM_CODE_WMODE
    } dmrm_code_e;
    typedef logic [15:0] dmrm_word_t;
    typedef struct packed {
        logic rsp_valid;
        logic rsp_err;
        dmrm_code_e code;
        dmrm_word_t rdata;
        dmrm_word_t bc_op;
        dmrm_word_t bc_freq;
        dmrm_word_t op_word;
        logic commit;
        logic nv_store;
    } dmrm_regs_s;
endpackage

// ---- hdl/dmrm_sticky_flags.sv ----
// sticky error flags: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module dmrm_sticky_flags #(
    parameter int W = 7
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [W-1:0] i_set,
    input wire logic i_clr,
    output logic [W-1:0] o_flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } dmrm_sticky_s;
    dmrm_sticky_s q;
    dmrm_sticky_s next_q;

    always_comb begin
        next_q = q;
        next_q.flags = (i_clr ? '0 : q.flags) | i_set; // R7
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign o_flags = q.flags;

    property p_flag_hold;
        @(posedge i_mclk) disable iff (i_reset)
        (o_flags[0] && !i_clr) |=> o_flags[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear"); // R7

    property p_set_wins;
        @(posedge i_mclk) disable iff (i_reset)
        (i_set[0] && i_clr) |=> o_flags[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear"); // R7
endmodule // dmrm_sticky_flags
`default_nettype wire

// ---- hdl/dmrm_top.sv ----
// drive monitor register map: status, monitors, broadcast and commit
//
// Contract
// R1 - status bit A: run source not communications
// R2 - status bits B,C,D: overtorque, ref lost, retry
// R3 - bit E any fault, bit F link timeout
// R4 - output status mirrors relays and photocouplers
// R5 - PID feedback unsigned, ten counts per percent
// R6 - PID input/output signed, ten per percent
// R7 - link errors sticky until fault reset
// R8 - broadcast bit0 run, bit1 reverse
// R9 - broadcast bit4 external fault, bit5 reset
// R10 - broadcast bits C-F drive inputs five-eight
// R11 - broadcast writable; frequency 30000 is full
// R12 - undefined broadcast bits keep local values
// R13 - parameter writes staged until commit
// R14 - zero to commit; 0900H also nonvolatile
// R15 - 0910H commit updates working memory only
// R16 - reading commit registers gives error 02H
// R17 - master avoids frequent nonvolatile commits
// R18 - DC bus, torque, power monitors readable
// R19 - broadcast to other address gives 02H
// R20 - parameter write while running gives 22H
// R21 - unused bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "dmrm_defs.svh"
module dmrm_top (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic i_req_bcast,
    input wire logic [15:0] i_req_addr,
    input wire logic [15:0] i_req_wdata,
    output logic o_rsp_valid,
    output logic o_rsp_err,
    output dmrm_pkg::dmrm_code_e o_rsp_code,
    output logic [15:0] o_rsp_rdata,
    input wire logic i_running,
    input wire logic [9:0] i_status_low,
    input wire logic i_run_src_not_comm,
    input wire logic i_overtorque,
    input wire logic i_ref_lost,
    input wire logic i_retrying,
    input wire logic i_fault,
    input wire logic i_comm_timeout,
    input wire logic [2:0] i_relay_out,
    input wire logic [1:0] i_photocoupler_output,
    input wire logic [15:0] i_dc_bus,
    input wire logic [15:0] i_torque,
    input wire logic [15:0] i_output_power_monitor_item,
    input wire logic [15:0] i_pid_feedback,
    input wire logic [15:0] i_pid_input,
    input wire logic [15:0] i_pid_output,
    input wire logic [15:0] i_fw_main,
    input wire logic [15:0] i_fw_flash,
    input wire logic [15:0] i_kva,
    input wire logic [15:0] i_ctrl_method,
    input wire logic [6:0] i_link_err_evt,
    input wire logic i_fault_reset,
    input wire logic [15:0] i_local_op,
    output logic [15:0] o_op_word,
    output logic o_run_cmd,
    output logic o_reverse,
    output logic o_ext_fault,
    output logic o_fault_reset_req,
    output logic [3:0] o_contact_input,
    output logic [15:0] o_freq_ref,
    output logic o_commit,
    output logic o_nv_store
);
    import dmrm_pkg::*;

    dmrm_regs_s q;
    dmrm_regs_s next_q;
    logic [6:0] link_err;
    logic link_clr;
    logic stage_we;
    logic [2:0] pidx;
    logic [15:0] param_rdata;
    logic param_hit;
    logic [15:0] rd;
    logic rd_hit;
    logic ro_hit;
    logic [15:0] drive_status;

    assign pidx = i_req_addr[2:0];
    assign param_hit = (i_req_addr[15:3] == 13'(`DMRM_A_PARAM_BASE >> 3));

    assign drive_status = {
        i_comm_timeout, // R3
        i_fault | i_comm_timeout, // R3
        i_retrying, // R2
        i_ref_lost, // R2
        i_overtorque, // R2
        i_run_src_not_comm, // R1
        i_status_low
    };

    // read decode; the commit registers have no read path on purpose
    always_comb begin
        rd = 16'h0000;
        rd_hit = 1'b1;
        ro_hit = 1'b1;
        unique case (i_req_addr)
            `DMRM_A_BC_OP: begin
                rd = q.bc_op;
                ro_hit = 1'b0;
            end
            `DMRM_A_BC_FREQ: begin
                rd = q.bc_freq;
                ro_hit = 1'b0;
            end
            `DMRM_A_DRV_STAT: rd = drive_status;
            `DMRM_A_OUT_STAT: rd = {11'h000, i_photocoupler_output, i_relay_out}; // R4 R21
            `DMRM_A_DC_BUS: rd = i_dc_bus; // R18
            `DMRM_A_TORQUE: rd = i_torque; // R18
            `DMRM_A_POWER: rd = i_output_power_monitor_item; // R18
            `DMRM_A_PID_FB: rd = i_pid_feedback; // R5
            `DMRM_A_PID_IN: rd = i_pid_input; // R6
            `DMRM_A_PID_OUT: rd = i_pid_output; // R6
            `DMRM_A_FW_MAIN: rd = i_fw_main;
            `DMRM_A_FW_FLASH: rd = i_fw_flash;
            `DMRM_A_LINK_ERR: rd = {9'h000, link_err & `DMRM_LINK_ERR_MASK}; // R7 R21
            `DMRM_A_KVA: rd = i_kva;
            `DMRM_A_CTRL: rd = i_ctrl_method;
            default: begin
                rd = param_rdata;
                rd_hit = param_hit;
                ro_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_q = q;
        next_q.rsp_valid = 1'b0;
        next_q.commit = 1'b0;
        next_q.nv_store = 1'b0;
        stage_we = 1'b0;
        link_clr = i_fault_reset; // R7
        // defined broadcast bits come from the master, the rest stay local
        next_q.op_word = (q.bc_op & `DMRM_BC_DEF_MASK)
            | (i_local_op & ~`DMRM_BC_DEF_MASK); // R12
        if (i_req_valid) begin
            next_q.rsp_valid = 1'b1;
            next_q.rsp_err = 1'b0;
            next_q.code = DMRM_OK;
            next_q.rdata = 16'h0000;
            if (i_req_bcast && (!i_req_write || i_req_addr > `DMRM_A_BC_FREQ)) begin
                next_q.rsp_err = 1'b1; // R19
                next_q.code = DMRM_BAD_REG; // R19
            end else if (i_req_write) begin
                if (i_req_addr == `DMRM_A_BC_OP) begin
                    next_q.bc_op = i_req_wdata & `DMRM_BC_DEF_MASK; // R8 R9 R10 R21
                    link_clr = i_fault_reset | i_req_wdata[`DMRM_BIT_FAULT_RST]; // R7 R9
                end else if (i_req_addr == `DMRM_A_BC_FREQ) begin
                    next_q.bc_freq = i_req_wdata; // R11
                end else if (i_req_addr == `DMRM_A_BC_NONE && i_req_bcast) begin
                    next_q.code = DMRM_OK;
                end else if (i_req_addr == `DMRM_A_COMMIT_NV
                    || i_req_addr == `DMRM_A_COMMIT_RAM) begin
                    if (i_running) begin
                        next_q.rsp_err = 1'b1;
                        next_q.code = DMRM_WMODE;
                    end else if (i_req_wdata == 16'h0000) begin
                        next_q.commit = 1'b1; // R14 R15
                        next_q.nv_store = (i_req_addr == `DMRM_A_COMMIT_NV); // R14 R15
                    end
                end else if (param_hit) begin
                    if (i_running) begin
                        next_q.rsp_err = 1'b1; // R20
                        next_q.code = DMRM_WMODE; // R20
                    end else begin
                        stage_we = 1'b1; // R13
                    end
                end else if (rd_hit && ro_hit) begin
                    next_q.rsp_err = 1'b1;
                    next_q.code = DMRM_WMODE;
                end else begin
                    next_q.rsp_err = 1'b1;
                    next_q.code = DMRM_BAD_REG;
                end
            end else if (rd_hit) begin
                next_q.rdata = rd;
            end else begin
                next_q.rsp_err = 1'b1; // R16
                next_q.code = DMRM_BAD_REG; // R16
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    dmrm_sticky_flags #(
        .W(7)
    ) u_link_err (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_set(i_link_err_evt & `DMRM_LINK_ERR_MASK),
        .i_clr(link_clr),
        .o_flags(link_err)
    );

    dmrm_param_bank u_params (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_we(stage_we),
        .i_widx(pidx),
        .i_wdata(i_req_wdata),
        .i_commit(q.commit),
        .i_ridx(pidx),
        .o_rdata(param_rdata)
    );

    assign o_rsp_valid = q.rsp_valid;
    assign o_rsp_err = q.rsp_err;
    assign o_rsp_code = q.code;
    assign o_rsp_rdata = q.rdata;
    assign o_op_word = q.op_word;
    assign o_run_cmd = q.op_word[`DMRM_BIT_RUN]; // R8
    assign o_reverse = q.op_word[`DMRM_BIT_REV]; // R8
    assign o_ext_fault = q.op_word[`DMRM_BIT_EXT_FAULT]; // R9
    assign o_fault_reset_req = q.op_word[`DMRM_BIT_FAULT_RST]; // R9
    assign o_contact_input = q.op_word[15:`DMRM_BIT_CONTACT_LO]; // R10
    assign o_freq_ref = q.bc_freq; // R11
    assign o_commit = q.commit;
    assign o_nv_store = q.nv_store;

    sequence s_req(logic w, logic [15:0] a);
        i_req_valid && i_req_write == w && !i_req_bcast && i_req_addr == a;
    endsequence

    // a commit only fires on a zero write while stopped
    sequence s_commit0(logic [15:0] a);
        i_req_valid && i_req_write && !i_req_bcast && i_req_addr == a
            && i_req_wdata == 16'h0000 && !i_running;
    endsequence

    property p_rsp_next;
        @(posedge i_mclk) disable iff (i_reset)
        i_req_valid |=> o_rsp_valid ##1 !o_rsp_valid || $past(i_req_valid);
    endproperty
    a_rsp_next: assert property (p_rsp_next) else $error("response missing");

    property p_err_no_data;
        @(posedge i_mclk) disable iff (i_reset)
        (o_rsp_valid && o_rsp_err) |-> o_rsp_rdata == 16'h0000;
    endproperty
    a_err_no_data: assert property (p_err_no_data) else $error("data on error answer");

    property p_commit_read;
        @(posedge i_mclk) disable iff (i_reset)
        (s_req(1'b0, `DMRM_A_COMMIT_NV) or s_req(1'b0, `DMRM_A_COMMIT_RAM))
            |=> o_rsp_err && o_rsp_code == DMRM_BAD_REG;
    endproperty
    a_commit_read: assert property (p_commit_read) else $error("commit read not 02H"); // R16

    property p_run_write;
        @(posedge i_mclk) disable iff (i_reset)
        (i_req_valid && i_req_write && !i_req_bcast && param_hit && i_running)
            |=> o_rsp_code == DMRM_WMODE && !o_commit;
    endproperty
    a_run_write: assert property (p_run_write) else $error("run write not 22H"); // R20

    property p_nv_commit;
        @(posedge i_mclk) disable iff (i_reset)
        s_commit0(`DMRM_A_COMMIT_NV) |=> o_commit && o_nv_store;
    endproperty
    a_nv_commit: assert property (p_nv_commit) else $error("nv commit missed"); // R14

    property p_ram_commit;
        @(posedge i_mclk) disable iff (i_reset)
        s_commit0(`DMRM_A_COMMIT_RAM) |=> o_commit && !o_nv_store;
    endproperty
    a_ram_commit: assert property (p_ram_commit) else $error("ram commit wrong"); // R15

    property p_nonzero_commit;
        @(posedge i_mclk) disable iff (i_reset)
        o_commit |-> $past(i_req_wdata) == 16'h0000 && $past(i_req_write);
    endproperty
    a_nonzero_commit: assert property (p_nonzero_commit) else $error("commit w/o zero"); // R14

    property p_bcast_bad;
        @(posedge i_mclk) disable iff (i_reset)
        (i_req_valid && i_req_bcast && i_req_addr > `DMRM_A_BC_FREQ)
            |=> o_rsp_err && o_rsp_code == DMRM_BAD_REG;
    endproperty
    a_bcast_bad: assert property (p_bcast_bad) else $error("bad broadcast taken"); // R19

    property p_status_bits;
        @(posedge i_mclk) disable iff (i_reset)
        s_req(1'b0, `DMRM_A_DRV_STAT) |=> o_rsp_rdata[10] == $past(i_run_src_not_comm)
            && o_rsp_rdata[15] == $past(i_comm_timeout)
            && o_rsp_rdata[11] == $past(i_overtorque);
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status word wrong"); // R1

    property p_out_unused;
        @(posedge i_mclk) disable iff (i_reset)
        s_req(1'b0, `DMRM_A_OUT_STAT) |=> o_rsp_rdata[15:5] == 11'h000
            && o_rsp_rdata[2:0] == $past(i_relay_out);
    endproperty
    a_out_unused: assert property (p_out_unused) else $error("output status wrong"); // R4

    property p_local_bits;
        @(posedge i_mclk) disable iff (i_reset)
        // the merged word lags one edge, and is still zero on the edge after reset
        !$past(i_reset) |-> o_op_word[3:2] == $past(i_local_op[3:2])
            && o_op_word[11:6] == $past(i_local_op[11:6]);
    endproperty
    a_local_bits: assert property (p_local_bits) else $error("local bits lost"); // R12

    property p_bcast_run;
        @(posedge i_mclk) disable iff (i_reset)
        (i_req_valid && i_req_write && i_req_addr == `DMRM_A_BC_OP)
            ##1 (!i_req_valid) |=> o_run_cmd == $past(i_req_wdata[0], 2);
    endproperty
    a_bcast_run: assert property (p_bcast_run) else $error("run bit wrong"); // R8
endmodule // dmrm_top
`default_nettype wire
